// ==== src/smwc_regs.vh ====
// Purpose: constants for the deep-stop wake controller
// Assumes: 32-bit AHB-Lite slave, byte offsets in haddr[7:0]
// Notes: one aligned word per register
`ifndef SMWC_REGS_VH
`define SMWC_REGS_VH
`define SMWC_AW 8
`define SMWC_DW 32
`define SMWC_OFF_MODE 8'h00
`define SMWC_OFF_CTRL 8'h04
`define SMWC_OFF_SETTLE 8'h08
`define SMWC_OFF_FILT 8'h0c
`define SMWC_OFF_STAT 8'h10
`define SMWC_MODE_W 2
`define SMWC_MODE_RST 2'h0
`define SMWC_MODE_MID_IDLE 2'h0
`define SMWC_MODE_STOP_LO 2'h1
`define SMWC_MODE_STOP_HI 2'h3
`define SMWC_CTL_STOP_REQ 1
`define SMWC_CTL_NM_MASK0 4
`define SMWC_CTL_NM_MASK1 5
`define SMWC_CTL_IRQ_MASK 6
`define SMWC_MASK_RST 1'h0
`define SMWC_SEL_W 3
`define SMWC_SEL_RST 3'h6
`define SMWC_SETTLE_LOG2 10
`define SMWC_SETTLE_MARGIN 8
`define SMWC_FILT_W 4
`define SMWC_FILT_EN 3
`define SMWC_FILT_SEL_HI 2
`define SMWC_FILT_SEL_LO 0
`define SMWC_FILT_RST 4'h0
`define SMWC_FILT_SLOW_MIN 3'h3
`define SMWC_FILT_PIN 3
`define SMWC_NPINS 15
`define SMWC_NCSI 3
`define SMWC_NUART 4
`define SMWC_NSYNC 22
`define SMWC_ST_STATE_HI 2
`define SMWC_ST_STATE_LO 0
`define SMWC_ST_NMI 4
`define SMWC_ST_RST 5
`define SMWC_ST_ADC_INV 6
`define SMWC_ST_PIN_BLK 7
`define SMWC_TM_INT_DIV8 2'h1
`define SMWC_TM_SUB 2'h2
`endif

// ==== src/smwc_sync.v ====
// Purpose: two-flop level synchroniser, W bits wide
// Assumes: each bit is an independent level
// Notes: meta_q is read by q only
`timescale 1ns/1ps
`default_nettype none
module smwc_sync #(
  parameter W = 1
) (
  input wire clock, // main clock
  input wire reset, // sync reset, active high
  input wire [W-1:0] d, // asynchronous levels
  output reg [W-1:0] q // synchronised levels
);
  reg [W-1:0] meta_q;
  always @(posedge clock) begin
    if (reset) begin
      meta_q <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // smwc_sync
`default_nettype wire

// ==== src/smwc_top.v ====
// Purpose: deep-stop entry, wake detection, settle timing, clock gates
// Assumes: AHB-Lite word accesses; wake pins are asynchronous
// Notes: Contract
// Contract
// R1: idle wake counts selected settle interval
// R2: reset wake settles with default select
// R3: stop only from run, mode 01/11
// R4: stop halts main oscillator and clocks
// R5: execution stops, ram and subclock kept
// R6: software puts five nops after request
// R7: pending unmasked request exits stop immediately
// R8: listed interrupts and resets end stop
// R9: run resumes only after settle interval
// R10: masked release sources are ignored
// R11: slow noise filter blocks pin three
// R12: any unmasked request wakes, any priority
// R13: lower priority in handler: wake, no ack
// R14: higher priority or nmi: wake, ack
// R15: resume branches or continues per state
// R16: reset wake acts as ordinary reset
// R17: pll, cpu, dma, timers, intc stop
// R18: interval, watch timers, key per clock
// R19: watchdog, serial channels per clock source
// R20: converter stops, result undefined
// R21: ports and internal data held
// R22: running conversion halts, restarts, flagged invalid
// R23: interrupt wake uses selected settle count
// R24: counter cleared at wake, gates closed
// R25: wake sources synchronised before use
`timescale 1ns/1ps
`default_nettype none
`include "smwc_regs.vh"
module smwc_top #(
  parameter SETTLE_BASE_LOG2 = `SMWC_SETTLE_LOG2
) (
  input wire clock, // main clock, 100 MHz
  input wire reset, // sync reset, active high
  input wire hsel, // AHB select
  input wire [31:0] haddr, // AHB address
  input wire [1:0] htrans, // AHB transfer type
  input wire hwrite, // AHB write
  input wire [2:0] hsize, // AHB size, word only
  input wire [31:0] hwdata, // AHB write data
  input wire hready, // AHB bus ready
  output reg hreadyout, // AHB slave ready
  output reg [31:0] hrdata, // AHB read data
  output reg hresp, // AHB response, OKAY
  input wire nmi_pin, // non-maskable pin, async
  input wire watchdog_nonmask_irq, // watchdog nmi, async
  input wire [14:0] external_irq_pins, // pin irqs, async
  input wire [14:0] external_irq_unmask, // pin irq unmasked
  input wire periph_irq_unmasked, // running periph irq, async
  input wire reset_pin, // reset pin, async
  input wire watchdog_reset_signal, // watchdog reset, async
  input wire power_on_clear, // power-on clear, async
  input wire low_voltage_detector, // low-voltage reset, async
  input wire irq_pending_unmasked, // intc pending request
  input wire in_handler, // cpu is inside a handler
  input wire req_priority_higher, // request beats current
  input wire irq_enabled_state, // cpu interrupts enabled
  input wire adc_busy, // conversion in progress
  input wire [1:0] interval_timer_src, // interval timer clock
  input wire watch_timer_on_sub, // watch timer on subclock
  input wire watchdog_on_internal, // watchdog on internal osc
  input wire [2:0] serial_clock_input_sel, // csi on ext clock
  input wire async_baud_clock_input_sel, // uart0 on ext baud
  output reg main_osc_enable, // main oscillator runs
  output reg pll_enable, // pll runs
  output reg cpu_clk_en, // cpu clock gate
  output reg dma_clk_en, // dma clock gate
  output reg timer_grp_clk_en, // timer groups a and b
  output reg intc_clk_en, // interrupt controller clock
  output reg interval_timer_clk_en, // interval timer gate
  output reg watch_timer_clk_en, // watch timer gate
  output reg watchdog_clk_en, // watchdog gate
  output reg [2:0] clocked_serial_clk_en, // csi gates
  output reg [3:0] async_serial_clk_en, // uart gates
  output reg key_interrupt_clk_en, // key interrupt gate
  output reg adc_clk_en, // converter control gate
  output reg adc_restart, // restart conversion, pulse
  output reg adc_result_invalid, // converter result bad
  output reg port_hold, // ports keep their state
  output reg ram_retain, // ram and registers held
  output reg core_reset, // core held in reset
  output reg resume_branch, // go to handler, pulse
  output reg resume_next, // next instruction, pulse
  output reg irq_ack // acknowledge request, pulse
);
  localparam S_RUN = 3'h0;
  localparam S_STOP = 3'h1;
  localparam S_IDLE = 3'h2;
  localparam S_SETTLE = 3'h3;
  localparam S_RSETTLE = 3'h4;
  localparam CW = SETTLE_BASE_LOG2 + `SMWC_SETTLE_MARGIN;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [CW-1:0] cnt_q;
  reg [`SMWC_MODE_W-1:0] mode_q;
  reg nm_mask0_q;
  reg nm_mask1_q;
  reg irq_mask_q;
  reg [`SMWC_SEL_W-1:0] sel_q;
  reg [`SMWC_FILT_W-1:0] filt_q;
  reg cause_nmi_q;
  reg cause_rst_q;
  reg adc_pend_q;
  reg [`SMWC_AW-1:0] addr_q;
  reg wr_q;
  reg rd_q;
  reg [31:0] rd_mux;
  wire [`SMWC_NSYNC-1:0] sync_q;

  // R25: async wake sources resynced first; irq_pending_unmasked used as is
  smwc_sync #(
    .W(`SMWC_NSYNC)
  ) u_sync (
    .clock(clock),
    .reset(reset),
    .d({low_voltage_detector, power_on_clear, watchdog_reset_signal,
        reset_pin, periph_irq_unmasked, watchdog_nonmask_irq, nmi_pin,
        external_irq_pins}),
    .q(sync_q)
  );

  wire [14:0] ext_s = sync_q[`SMWC_NPINS-1:0];
  wire nmi_s = sync_q[`SMWC_NPINS];
  wire wdn_s = sync_q[`SMWC_NPINS+1];
  wire per_s = sync_q[`SMWC_NPINS+2];
  wire rst_s = |sync_q[`SMWC_NSYNC-1:`SMWC_NPINS+3];

  // R11: slow filter sampling cannot run without main clock
  wire pin_blk = filt_q[`SMWC_FILT_EN] &
    (filt_q[`SMWC_FILT_SEL_HI:`SMWC_FILT_SEL_LO] >= `SMWC_FILT_SLOW_MIN);
  wire [14:0] blk_vec = pin_blk ? (15'h1 << `SMWC_FILT_PIN) : 15'h0;
  wire [14:0] ext_ok = ext_s & external_irq_unmask & ~blk_vec;
  // R10: a set mask bit drops its source
  wire nm_wake = (nmi_s & ~nm_mask0_q) | (wdn_s & ~nm_mask1_q);
  // R12: priority plays no part in waking
  wire mk_wake = ((|ext_ok) | per_s | irq_pending_unmasked) & ~irq_mask_q;
  // R8: wake on any enabled interrupt source
  wire wake_any = nm_wake | mk_wake;

  // AHB-Lite: writes zero wait, reads one wait state
  wire take = hsel & htrans[1] & hready;
  wire we_mode = wr_q & (addr_q == `SMWC_OFF_MODE);
  wire we_ctrl = wr_q & (addr_q == `SMWC_OFF_CTRL);
  wire we_sel = wr_q & (addr_q == `SMWC_OFF_SETTLE);
  wire we_filt = wr_q & (addr_q == `SMWC_OFF_FILT);
  wire we_stat = wr_q & (addr_q == `SMWC_OFF_STAT);
  wire mode_stop = (mode_q == `SMWC_MODE_STOP_LO) |
    (mode_q == `SMWC_MODE_STOP_HI);
  // R3: request honoured only in run
  wire stop_wr = we_ctrl & hwdata[`SMWC_CTL_STOP_REQ] & (state_q == S_RUN);

  // R23: interval is 2^(base+select) cycles
  wire [CW-1:0] one_w = {{(CW-1){1'b0}}, 1'b1};
  wire [CW-1:0] limit = (one_w << (SETTLE_BASE_LOG2 + sel_q)) - one_w;
  wire done = (cnt_q == limit);
  wire settling = (state_q == S_SETTLE) | (state_q == S_RSETTLE);
  wire now_resume = stop_wr & wake_any;
  wire resume_ev = now_resume |
    ((state_q == S_SETTLE) & done & ~rst_s);
  wire branch_src = (state_q == S_RUN) ? nm_wake : cause_nmi_q;
  // R13: lower priority in handler is not taken
  // R14: higher priority with interrupts enabled, or nmi, is taken
  wire branch = branch_src |
    (irq_enabled_state & (~in_handler | req_priority_higher));

  always @* begin
    state_d = state_q;
    case (state_q)
      S_RUN: begin
        // R7: pending request cancels the entry
        if (stop_wr & ~wake_any) begin
          if (mode_stop) begin
            state_d = S_STOP;
          end else if (mode_q == `SMWC_MODE_MID_IDLE) begin
            state_d = S_IDLE;
          end
        end
      end
      S_STOP, S_IDLE: begin
        if (wake_any) begin
          state_d = S_SETTLE;
        end
      end
      S_SETTLE: begin
        // R9: run only after the interval
        if (done) begin
          state_d = S_RUN;
        end
      end
      S_RSETTLE: begin
        if (done & ~rst_s) begin
          state_d = S_RUN;
        end
      end
      default: begin
        state_d = S_RSETTLE;
      end
    endcase
    // R16: any reset source restarts as a normal reset
    if (rst_s) begin
      state_d = S_RSETTLE;
    end
  end

  always @* begin
    rd_mux = 32'h0;
    case (addr_q)
      `SMWC_OFF_MODE: begin
        rd_mux[`SMWC_MODE_W-1:0] = mode_q;
      end
      `SMWC_OFF_CTRL: begin
        rd_mux[`SMWC_CTL_NM_MASK0] = nm_mask0_q;
        rd_mux[`SMWC_CTL_NM_MASK1] = nm_mask1_q;
        rd_mux[`SMWC_CTL_IRQ_MASK] = irq_mask_q;
      end
      `SMWC_OFF_SETTLE: begin
        rd_mux[`SMWC_SEL_W-1:0] = sel_q;
      end
      `SMWC_OFF_FILT: begin
        rd_mux[`SMWC_FILT_W-1:0] = filt_q;
      end
      `SMWC_OFF_STAT: begin
        rd_mux[`SMWC_ST_STATE_HI:`SMWC_ST_STATE_LO] = state_q;
        rd_mux[`SMWC_ST_NMI] = cause_nmi_q;
        rd_mux[`SMWC_ST_RST] = cause_rst_q;
        rd_mux[`SMWC_ST_ADC_INV] = adc_result_invalid;
        rd_mux[`SMWC_ST_PIN_BLK] = pin_blk;
      end
      default: begin
        rd_mux = 32'h0;
      end
    endcase
  end

  always @(posedge clock) begin
    if (reset) begin
      addr_q <= {`SMWC_AW{1'b0}};
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= 32'h0;
      hresp <= 1'b0;
    end else begin
      wr_q <= take & hwrite;
      rd_q <= take & ~hwrite;
      if (take) begin
        addr_q <= haddr[`SMWC_AW-1:0];
      end
      // read data taken one cycle late so a write just before is seen
      if (rd_q) begin
        hrdata <= rd_mux;
        hreadyout <= 1'b1;
      end else if (take & ~hwrite) begin
        hreadyout <= 1'b0;
      end
    end
  end

  // R2: reset wake reloads the default select
  always @(posedge clock) begin
    if (reset | (state_q == S_RSETTLE)) begin
      mode_q <= `SMWC_MODE_RST;
      nm_mask0_q <= `SMWC_MASK_RST;
      nm_mask1_q <= `SMWC_MASK_RST;
      irq_mask_q <= `SMWC_MASK_RST;
      sel_q <= `SMWC_SEL_RST;
      filt_q <= `SMWC_FILT_RST;
    end else begin
      if (we_mode) begin
        mode_q <= hwdata[`SMWC_MODE_W-1:0];
      end
      if (we_ctrl) begin
        nm_mask0_q <= hwdata[`SMWC_CTL_NM_MASK0];
        nm_mask1_q <= hwdata[`SMWC_CTL_NM_MASK1];
        irq_mask_q <= hwdata[`SMWC_CTL_IRQ_MASK];
      end
      if (we_sel) begin
        sel_q <= hwdata[`SMWC_SEL_W-1:0];
      end
      if (we_filt) begin
        filt_q <= hwdata[`SMWC_FILT_W-1:0];
      end
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      state_q <= S_RSETTLE;
      cnt_q <= {CW{1'b0}};
      cause_nmi_q <= 1'b0;
      cause_rst_q <= 1'b1;
      adc_pend_q <= 1'b0;
      adc_result_invalid <= 1'b0;
      adc_restart <= 1'b0;
      resume_branch <= 1'b0;
      resume_next <= 1'b0;
      irq_ack <= 1'b0;
    end else begin
      state_q <= state_d;
      // R24: counter held clear until wake, then free to run
      // R1: idle and stop share the same timer
      if (settling & (state_d == state_q) & ~rst_s) begin
        cnt_q <= cnt_q + one_w;
      end else begin
        cnt_q <= {CW{1'b0}};
      end
      if (((state_q == S_STOP) | (state_q == S_IDLE)) & wake_any) begin
        cause_nmi_q <= nm_wake;
        cause_rst_q <= 1'b0;
      end else if (now_resume) begin
        cause_nmi_q <= nm_wake;
        cause_rst_q <= 1'b0;
      end
      if (rst_s) begin
        cause_rst_q <= 1'b1;
        cause_nmi_q <= 1'b0;
      end
      // R15: resume path from cause and enable state
      resume_branch <= resume_ev & branch;
      resume_next <= resume_ev & ~branch;
      irq_ack <= resume_ev & branch;
      // R22: halted conversion restarts, results flagged
      adc_restart <= resume_ev & adc_pend_q;
      if (rst_s) begin
        adc_pend_q <= 1'b0;
      end else if (state_q == S_RUN & state_d == S_STOP & adc_busy) begin
        adc_pend_q <= 1'b1;
      end else if (resume_ev) begin
        adc_pend_q <= 1'b0;
      end
      // set beats a same-cycle write-one clear
      if (state_q == S_RUN & state_d == S_STOP & adc_busy) begin
        adc_result_invalid <= 1'b1;
      end else if (we_stat & hwdata[`SMWC_ST_ADC_INV]) begin
        adc_result_invalid <= 1'b0;
      end
    end
  end

  // gates follow the next state so they close with the entry edge
  wire gated_d = (state_d != S_RUN);
  wire hold_d = gated_d & (state_d != S_RSETTLE);
  always @(posedge clock) begin
    if (reset) begin
      main_osc_enable <= 1'b1;
      pll_enable <= 1'b0;
      cpu_clk_en <= 1'b0;
      dma_clk_en <= 1'b0;
      timer_grp_clk_en <= 1'b0;
      intc_clk_en <= 1'b0;
      interval_timer_clk_en <= 1'b0;
      watch_timer_clk_en <= 1'b0;
      watchdog_clk_en <= 1'b0;
      clocked_serial_clk_en <= {`SMWC_NCSI{1'b0}};
      async_serial_clk_en <= {`SMWC_NUART{1'b0}};
      key_interrupt_clk_en <= 1'b1;
      adc_clk_en <= 1'b0;
      port_hold <= 1'b0;
      ram_retain <= 1'b0;
      core_reset <= 1'b1;
    end else begin
      // R4: only deep-stop halts the main oscillator
      main_osc_enable <= (state_d != S_STOP);
      // R17: core-side blocks stop; wake logic stays here
      pll_enable <= ~gated_d;
      cpu_clk_en <= ~gated_d;
      dma_clk_en <= ~gated_d;
      timer_grp_clk_en <= ~gated_d;
      intc_clk_en <= ~gated_d;
      // R18: timers on slow clocks keep counting
      interval_timer_clk_en <= ~gated_d |
        (interval_timer_src == `SMWC_TM_INT_DIV8) |
        (interval_timer_src == `SMWC_TM_SUB);
      watch_timer_clk_en <= ~gated_d | watch_timer_on_sub;
      key_interrupt_clk_en <= 1'b1;
      // R19: watchdog and serial only on own clocks
      watchdog_clk_en <= ~gated_d | watchdog_on_internal;
      clocked_serial_clk_en <= gated_d ? serial_clock_input_sel :
        {`SMWC_NCSI{1'b1}};
      async_serial_clk_en <= gated_d ?
        {{(`SMWC_NUART-1){1'b0}}, async_baud_clock_input_sel} :
        {`SMWC_NUART{1'b1}};
      // R20: converter control stopped while gated
      adc_clk_en <= ~gated_d;
      // R5: execution halted, ram kept
      // R21: ports and state frozen, not reset
      port_hold <= hold_d;
      ram_retain <= hold_d;
      core_reset <= (state_d == S_RSETTLE);
    end
  end
endmodule // smwc_top
`default_nettype wire

// ==== testbench/smwc_cpu_model.sv ====
// Purpose: stand-in for the interrupt controller and core
// Assumes: resume and ack outputs are one-cycle pulses
// Notes: counts what the core would do after each wake
`timescale 1ns/1ps
`default_nettype none
module smwc_cpu_model (
  input wire logic clock, // main clock
  input wire logic reset, // sync reset
  input wire logic resume_branch, // branch pulse
  input wire logic resume_next, // next pulse
  input wire logic irq_ack, // ack pulse
  input wire logic raise_req, // request from a source
  output logic irq_pending_unmasked, // held request
  output int n_branch, // branches seen
  output int n_next, // continues seen
  output int n_ack // acks seen
);
  always @(posedge clock) begin
    if (reset) begin
      irq_pending_unmasked <= 1'b0;
      n_branch <= 0;
      n_next <= 0;
      n_ack <= 0;
    end else begin
      irq_pending_unmasked <= raise_req && !irq_ack;
      n_branch <= n_branch + int'(resume_branch === 1'b1);
      n_next <= n_next + int'(resume_next === 1'b1);
      n_ack <= n_ack + int'(irq_ack === 1'b1);
    end
  end
endmodule // smwc_cpu_model
`default_nettype wire

// ==== testbench/smwc_top_properties.sv ====
// Purpose: port checks for the deep-stop wake controller
// Assumes: one clock, sync active-high reset
// Notes: deep stop is seen as main oscillator off
`timescale 1ns/1ps
`default_nettype none
module smwc_top_properties (
  input wire logic clock, // clock
  input wire logic reset, // reset
  input wire logic reset_pin, // reset pin
  input wire logic main_osc_enable, // oscillator
  input wire logic pll_enable, // gate
  input wire logic cpu_clk_en, // gate
  input wire logic dma_clk_en, // gate
  input wire logic timer_grp_clk_en, // gate
  input wire logic [1:0] interval_timer_src, // source
  input wire logic interval_timer_clk_en, // gate
  input wire logic watch_timer_on_sub, // source
  input wire logic watch_timer_clk_en, // gate
  input wire logic watchdog_on_internal, // source
  input wire logic watchdog_clk_en, // gate
  input wire logic [2:0] serial_clock_input_sel, // sources
  input wire logic [2:0] clocked_serial_clk_en, // gates
  input wire logic async_baud_clock_input_sel, // source
  input wire logic [3:0] async_serial_clk_en, // gates
  input wire logic key_interrupt_clk_en, // gate
  input wire logic adc_clk_en, // gate
  input wire logic port_hold, // ports frozen
  input wire logic ram_retain, // data kept
  input wire logic core_reset, // core reset
  input wire logic resume_branch, // pulse
  input wire logic resume_next, // pulse
  input wire logic irq_ack // pulse
);
  wire logic stop = !main_osc_enable;
  wire logic core_off = !cpu_clk_en && !pll_enable && !dma_clk_en
    && !timer_grp_clk_en;
  wire logic tmr_ok = key_interrupt_clk_en && (watch_timer_clk_en
    == watch_timer_on_sub) && (interval_timer_clk_en
    == (interval_timer_src == 2'h1 || interval_timer_src == 2'h2));
  wire logic ser_ok = clocked_serial_clk_en == serial_clock_input_sel
    && async_serial_clk_en == {3'h0, async_baud_clock_input_sel}
    && watchdog_clk_en == watchdog_on_internal;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  sequence s_osc_back;
    $rose(main_osc_enable);
  endsequence
  sequence s_gates_shut;
    !cpu_clk_en [*4];
  endsequence
  a_settle_gates_shut: assert property (s_osc_back |-> s_gates_shut)
    else $error("cpu clock opened before settling");
  a_stop_core_off: assert property (stop |-> core_off)
    else $error("core clock running in stop");
  a_stop_from_run: assert property ($fell(main_osc_enable) |->
    $past(cpu_clk_en) && !core_reset)
    else $error("stop entered outside run");
  a_stop_data_held: assert property (stop |-> port_hold && ram_retain)
    else $error("ports or data not held in stop");
  a_stop_adc_off: assert property (stop |-> !adc_clk_en)
    else $error("converter clocked in stop");
  a_stop_timer_src: assert property (stop |-> tmr_ok)
    else $error("timer gates wrong in stop");
  a_stop_serial_src: assert property (stop |-> ser_ok)
    else $error("serial or watchdog gates wrong in stop");
  a_ack_with_branch: assert property (irq_ack |-> resume_branch)
    else $error("ack without branch");
  a_resume_one_pulse: assert property ((resume_branch || resume_next)
    |-> !(resume_branch && resume_next) ##1 !resume_branch && !resume_next)
    else $error("resume pulse malformed");
  a_reset_pin_wake: assert property ($rose(reset_pin) |->
    ##[1:4] core_reset)
    else $error("reset pin did not reset core");
endmodule // smwc_top_properties
bind smwc_top smwc_top_properties u_props (
  .clock, .reset, .reset_pin, .main_osc_enable, .pll_enable, .cpu_clk_en,
  .dma_clk_en, .timer_grp_clk_en, .interval_timer_src,
  .interval_timer_clk_en, .watch_timer_on_sub, .watch_timer_clk_en,
  .watchdog_on_internal, .watchdog_clk_en, .serial_clock_input_sel,
  .clocked_serial_clk_en, .async_baud_clock_input_sel,
  .async_serial_clk_en, .key_interrupt_clk_en, .adc_clk_en, .port_hold,
  .ram_retain, .core_reset, .resume_branch, .resume_next, .irq_ack
);
`default_nettype wire

// ==== testbench/smwc_top_tb.sv ====
// Purpose: self-checking bench for the deep-stop wake controller
// Assumes: settle base cut to 2, so select s waits 2^(2+s) cycles
// Notes: selects, modes and gate sources drawn from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module smwc_top_tb;
  localparam int BASE = 2;
  localparam int RST_WAIT = 1 << (BASE + 6);
  logic clock, reset, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, seed;
  logic [1:0] htrans, interval_timer_src, mode;
  logic [2:0] hsize, serial_clock_input_sel, cfg, sel;
  logic [8:0] srcs;
  logic [3:0] pin, async_serial_clk_en;
  logic [14:0] pins, external_irq_pins, external_irq_unmask;
  logic in_handler, req_priority_higher, irq_enabled_state, adc_busy;
  logic watch_timer_on_sub, watchdog_on_internal, raise_req;
  logic async_baud_clock_input_sel, irq_pending_unmasked, intc_clk_en;
  logic main_osc_enable, pll_enable, cpu_clk_en, dma_clk_en;
  logic timer_grp_clk_en, interval_timer_clk_en, watch_timer_clk_en;
  logic watchdog_clk_en, key_interrupt_clk_en, adc_clk_en, adc_restart;
  logic [2:0] clocked_serial_clk_en;
  logic adc_result_invalid, port_hold, ram_retain, core_reset;
  logic resume_branch, resume_next, irq_ack;
  int errors, total_checks, cyc, restarts, n, n_branch, n_next, n_ack;
  int b0, x0, a0, lim, s, eb;
  assign hready = hreadyout;
  assign external_irq_pins = pins | (15'(srcs[2]) << pin);
  smwc_top #(.SETTLE_BASE_LOG2(BASE)) dut (
    .clock, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hrdata, .hresp, .nmi_pin(srcs[0]),
    .watchdog_nonmask_irq(srcs[1]), .external_irq_pins,
    .external_irq_unmask, .periph_irq_unmasked(srcs[3] | srcs[8]),
    .reset_pin(srcs[4]), .watchdog_reset_signal(srcs[5]),
    .power_on_clear(srcs[6]), .low_voltage_detector(srcs[7]),
    .irq_pending_unmasked, .in_handler, .req_priority_higher,
    .irq_enabled_state, .adc_busy, .interval_timer_src,
    .watch_timer_on_sub, .watchdog_on_internal, .serial_clock_input_sel,
    .async_baud_clock_input_sel, .main_osc_enable, .pll_enable,
    .cpu_clk_en, .dma_clk_en, .timer_grp_clk_en, .intc_clk_en,
    .interval_timer_clk_en, .watch_timer_clk_en, .watchdog_clk_en,
    .clocked_serial_clk_en, .async_serial_clk_en, .key_interrupt_clk_en,
    .adc_clk_en, .adc_restart, .adc_result_invalid, .port_hold,
    .ram_retain, .core_reset, .resume_branch, .resume_next, .irq_ack
  );
  smwc_cpu_model partner (
    .clock, .reset, .resume_branch, .resume_next, .irq_ack, .raise_req,
    .irq_pending_unmasked, .n_branch, .n_next, .n_ack
  );
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    restarts <= restarts + int'(adc_restart === 1'b1);
    if (cyc > 30000) begin
      errors = errors + 1;
      report_and_stop;
    end
  end
  task automatic chk(input logic [31:0] seen, exp, input string what);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("ERROR %0t: %s seen %h want %h", $time, what, seen, exp);
    end
  endtask
  // address phase held until ready, data phase likewise
  task automatic bus(input logic w, input logic [7:0] a, input int d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask
  task automatic wait_open;
    n = 0;
    while (cpu_clk_en !== 1'b1) begin
      @(posedge clock);
      n++;
    end
  endtask
  task automatic enter_stop(input logic [1:0] md, input int sl, ctl);
    interval_timer_src <= 2'($urandom);
    {watch_timer_on_sub, watchdog_on_internal} <= 2'($urandom);
    serial_clock_input_sel <= 3'($urandom);
    async_baud_clock_input_sel <= 1'($urandom);
    bus(1'b1, 8'h08, sl);
    bus(1'b1, 8'h00, int'(md));
    bus(1'b1, 8'h04, ctl);
    bus(1'b1, 8'h04, ctl | 2);
    repeat (5) @(posedge clock);
  endtask
  initial begin
    reset = 1'b1;
    hsize = 3'h2;
    external_irq_unmask = 15'h7fff;
    {hsel, hwrite, htrans, haddr, hwdata, srcs, pins, pin, raise_req} = '0;
    {in_handler, req_priority_higher, irq_enabled_state, adc_busy} = '0;
    {interval_timer_src, watch_timer_on_sub, watchdog_on_internal} = '0;
    {serial_clock_input_sel, async_baud_clock_input_sel} = '0;
    seed = $urandom(81079);
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    wait_open;
    chk(n >= RST_WAIT && n <= RST_WAIT + 6, 1, "reset settle");
    bus(1'b0, 8'h08, 0);
    chk(rd, 6, "select default");
    bus(1'b1, 8'h40, -1);
    bus(1'b0, 8'h40, 0);
    chk(rd, 0, "unmapped read");
    chk(hresp, 0, "okay response");
    $display("test registers done");
    for (int k = 0; k < 27; k++) begin
      s = k % 9;
      cfg = 3'(k / 3);
      sel = 3'($urandom % 4);
      pin = 4'($urandom % 15);
      mode = (s == 8) ? 2'h0 : (($urandom % 2) ? 2'h3 : 2'h1);
      {in_handler, req_priority_higher, irq_enabled_state} <= cfg;
      {b0, x0, a0} = {n_branch, n_next, n_ack};
      enter_stop(mode, int'(sel), 0);
      chk(main_osc_enable, s == 8, "oscillator in standby");
      chk({cpu_clk_en, intc_clk_en}, 0, "cpu clock in standby");
      srcs[s] <= 1'b1;
      lim = (s >= 4 && s < 8) ? RST_WAIT : 1 << (BASE + sel);
      if (lim == RST_WAIT)
        repeat (s == 7 ? 300 : 3) @(posedge clock);
      if (lim == RST_WAIT)
        srcs[s] <= 1'b0;
      wait_open;
      srcs <= '0;
      chk(n >= lim && n <= lim + 6, 1, "settle length");
      repeat (3) @(posedge clock);
      eb = int'(s < 2 || (cfg[0] && (!cfg[2] || cfg[1])));
      if (lim != RST_WAIT) begin
        chk(n_branch - b0, eb, "branch count");
        chk(n_next - x0, 1 - eb, "continue count");
        chk(n_ack - a0, eb, "ack count");
      end
    end
    $display("test wake sources done");
    enter_stop(2'h1, 0, 32'h70);
    srcs <= 9'h10b;
    pins <= 15'h7fff;
    repeat (40) @(posedge clock);
    chk(cpu_clk_en, 0, "masked wake");
    srcs <= 9'h010;
    pins <= '0;
    repeat (3) @(posedge clock);
    srcs <= '0;
    wait_open;
    $display("test masks done");
    raise_req <= 1'b1;
    repeat (2) @(posedge clock);
    b0 = n_branch + n_next;
    enter_stop(2'h1, 0, 0);
    raise_req <= 1'b0;
    chk({main_osc_enable, cpu_clk_en}, 3, "pending exit");
    chk(n_branch + n_next - b0, 1, "pending resume");
    adc_busy <= 1'b1;
    a0 = restarts;
    enter_stop(2'h3, 1, 0);
    srcs <= 9'h001;
    wait_open;
    srcs <= '0;
    adc_busy <= 1'b0;
    repeat (3) @(posedge clock);
    chk(restarts - a0, 1, "converter restart");
    chk(adc_result_invalid, 1, "converter flag");
    bus(1'b0, 8'h10, 0);
    chk(rd[7:0], 8'h50, "status word");
    $display("test pending and converter done");
    for (int f = 0; f < 8; f++) begin
      bus(1'b1, 8'h0c, 8 + f);
      enter_stop(2'h1, 0, 0);
      pins[3] <= 1'b1;
      repeat (40) @(posedge clock);
      chk(cpu_clk_en, f < 3, "pin three wake");
      pins <= 15'h0001;
      @(posedge clock);
      wait_open;
      pins <= '0;
      repeat (2) @(posedge clock);
    end
    $display("test filter done");
    report_and_stop;
  end
endmodule // smwc_top_tb
`default_nettype wire
